// ==== testbench/sexu_pipe_model.sv ====
// Pipeline stand-in that presents instructions at the exception point
module sexu_pipe_model
    import sexu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Requests from the bench
    input wire logic go,
    input sexu_req_s go_req,
    // Towards the exception unit
    output logic pipe_valid,
    output sexu_req_s pipe_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle request lines start from a known pattern
    initial pipe_req = '0;

    // One-cycle issue; idle request lines churn every cycle
    always @(posedge clk) begin
        pipe_valid <= go && nrst;
        pipe_req <= go ? go_req : ~pipe_req;
    end
endmodule // sexu_pipe_model

// ==== testbench/testbench.sv ====
// Self-checking bench of the synchronous exception unit
module testbench
    import sexu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] CLR = 32'h0000_3b77;
    logic sys_clk, nrst, go, pipe_valid, mchk_event;
    logic exc_taken, exc_suppress, instr_commit;
    logic [15:0] exc_vector;
    logic [31:0] machine_state, return_addr, saved_state, syndrome;
    logic [31:0] fault_addr, ms, ra, ss, es, fa;
    sexu_req_s go_req, pipe_req;
    sexu_spr_wr_s spr_wr;
    int seed = 32'h2d198f3e;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    sexu_pipe_model sexu_pipe_model_i (.clk(sys_clk), .nrst(nrst),
        .go(go), .go_req(go_req), .pipe_valid(pipe_valid),
        .pipe_req(pipe_req));

    sexu_core sexu_core_i (.SYS_CLK(sys_clk), .NRST(nrst),
        .PIPE_VALID(pipe_valid), .PIPE_REQ(pipe_req),
        .MCHK_EVENT(mchk_event), .SPR_WR(spr_wr),
        .EXC_TAKEN(exc_taken), .EXC_VECTOR(exc_vector),
        .EXC_SUPPRESS(exc_suppress), .INSTR_COMMIT(instr_commit),
        .MACHINE_STATE(machine_state), .RETURN_ADDR(return_addr),
        .SAVED_STATE(saved_state), .SYNDROME(syndrome),
        .FAULT_ADDR(fault_addr));

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            conclude();
        end
    end

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Compare all state registers
    task automatic regs();
        check(machine_state, ms);
        check(return_addr, ra);
        check(saved_state, ss);
        check(syndrome, es);
        check(fault_addr, fa);
    endtask

    // Expected cause in priority order
    function automatic sexu_cause_e cause_of(sexu_req_s r, logic user);
        logic mis;
        mis = |r.operand_ea[1:0];
        if (r.cls == CLS_ILLEGAL || r.cls == CLS_FLOAT)
            return CAUSE_ILLEGAL;
        if (r.priv_only && user)
            return CAUSE_PRIV;
        if (r.cls == CLS_SYSCALL)
            return CAUSE_SYSCALL;
        if (r.cls == CLS_TRAP && r.trap_hit)
            return CAUSE_TRAP;
        if ((r.cls == CLS_CACHE_ZERO && (r.noncache || r.writethru)) ||
            ((r.cls == CLS_LOAD_RESERVE || r.cls == CLS_STORE_COND) && mis) ||
            (r.cls == CLS_CACHE_READ && !user && mis))
            return CAUSE_ALIGN;
        return CAUSE_NONE;
    endfunction

    // Build a request
    function automatic sexu_req_s mk(sexu_class_e c, logic [3:0] f,
                                     logic [31:0] ia, logic [31:0] oa);
        return '{c, f[3], f[2], f[1], f[0], ia, oa};
    endfunction

    // Software register write
    task automatic spr(input sexu_spr_e sel, input logic [31:0] d);
        @(posedge sys_clk);
        spr_wr <= '{en: 1'b1, sel: sel, data: d};
        @(posedge sys_clk);
        spr_wr.en <= 1'b0;
        #1;
        case (sel)
            SPR_MACHINE_STATE: ms = d;
            SPR_RETURN_ADDR: ra = d;
            SPR_SAVED_STATE: ss = d;
            SPR_SYNDROME: es = d & ~32'h0000_0070;
            default: fa = d;
        endcase
        regs();
    endtask

    // One instruction through the model, answer checked
    task automatic send(input sexu_req_s r);
        sexu_cause_e c;
        logic [15:0] vec;
        c = cause_of(r, ms[5]);
        @(posedge sys_clk);
        go <= 1'b1;
        go_req <= r;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        #1;
        vec = c == CAUSE_ALIGN ? 16'h0600 : c == CAUSE_SYSCALL ? 16'h0c00 :
              c == CAUSE_NONE ? 16'h0000 : 16'h0700;
        if (c != CAUSE_NONE) begin
            ss = ms;
            ms = ms & ~CLR;
            ra = r.instr_ea + (c == CAUSE_SYSCALL ? 32'h4 : 32'h0);
        end
        if (c == CAUSE_ALIGN)
            fa = r.operand_ea;
        if (c inside {CAUSE_ILLEGAL, CAUSE_PRIV, CAUSE_TRAP})
            es = {28'h0, c == CAUSE_TRAP, c == CAUSE_PRIV,
                  c == CAUSE_ILLEGAL, es[0]};
        check(exc_taken, c != CAUSE_NONE);
        check(exc_vector, vec);
        check(exc_suppress, c inside {CAUSE_ALIGN, CAUSE_ILLEGAL,
                                      CAUSE_PRIV});
        check(instr_commit, c inside {CAUSE_NONE, CAUSE_SYSCALL});
        regs();
        @(posedge sys_clk);
        #1;
        check(exc_taken | instr_commit, 1'b0);
    endtask

    // Main sequence
    initial begin
        sexu_req_s r;
        nrst = 1'b0;
        go = 1'b0;
        go_req = '0;
        mchk_event = 1'b0;
        spr_wr = '0;
        {ms, ra, ss, es, fa} = '0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        #1;
        regs();
        for (int s = 0; s < 5; s++)
            spr(sexu_spr_e'(s), 32'hffff_ffff);
        spr(SPR_MACHINE_STATE, 32'hffff_ffff);
        send(mk(CLS_FLOAT, 4'h0, 32'h100, 32'h0));
        send(mk(CLS_CACHE_READ, 4'h0, 32'h104, 32'h203));
        spr(SPR_MACHINE_STATE, 32'h0000_0020);
        send(mk(CLS_CACHE_READ, 4'h0, 32'h108, 32'h202));
        send(mk(CLS_CACHE_READ, 4'h8, 32'h10c, 32'h201));
        spr(SPR_MACHINE_STATE, 32'h0000_ffff);
        send(mk(CLS_SYSCALL, 4'h0, 32'hffff_fffc, 32'h0));
        send(mk(CLS_TRAP, 4'h0, 32'h110, 32'h0));
        send(mk(CLS_TRAP, 4'h1, 32'h114, 32'h0));
        send(mk(CLS_LOAD_RESERVE, 4'h0, 32'h118, 32'h302));
        send(mk(CLS_STORE_COND, 4'h0, 32'h11c, 32'h300));
        send(mk(CLS_CACHE_ZERO, 4'h4, 32'h120, 32'h400));
        send(mk(CLS_CACHE_ZERO, 4'h2, 32'h124, 32'h404));
        // Machine check must set a cleared bit, program entry keeps it
        spr(SPR_SYNDROME, 32'h0000_0000);
        @(posedge sys_clk);
        mchk_event <= 1'b1;
        @(posedge sys_clk);
        mchk_event <= 1'b0;
        es[0] = 1'b1;
        send(mk(CLS_ILLEGAL, 4'h0, 32'h128, 32'h0));
        for (int i = 0; i < 300; i++) begin
            if (i % 8 == 0)
                spr(SPR_MACHINE_STATE, $random(seed));
            r.cls = sexu_class_e'(4'({$random(seed)} % 9));
            {r.priv_only, r.noncache, r.writethru, r.trap_hit} =
                4'($random(seed));
            r.instr_ea = $random(seed);
            r.operand_ea = $random(seed);
            send(r);
        end
        // Reset in mid-run returns every register to zero
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        {ms, ra, ss, es, fa} = '0;
        @(posedge sys_clk);
        #1;
        regs();
        check(exc_taken | exc_suppress | instr_commit, 1'b0);
        check(exc_vector, 16'h0000);
        conclude();
    end
endmodule // testbench

// ==== verilog/sexu_cause_decode.sv ====
// Cause decoder of the synchronous exception unit
module sexu_cause_decode
    import sexu_pkg::*;
(
    // Instruction and mode
    input sexu_req_s req,
    input wire logic user_mode,
    // Result
    output sexu_cause_e cause
);

    // Priority: illegal, privilege, call, trap, then alignment
    always_comb begin
        cause = CAUSE_NONE;
        if (req.cls == CLS_ILLEGAL || req.cls == CLS_FLOAT) begin
            cause = CAUSE_ILLEGAL;
        end else if (req.priv_only && user_mode) begin
            cause = CAUSE_PRIV;
        end else if (req.cls == CLS_SYSCALL) begin
            cause = CAUSE_SYSCALL;
        end else if (req.cls == CLS_TRAP && req.trap_hit) begin
            cause = CAUSE_TRAP;
        end else if (req.cls == CLS_CACHE_ZERO &&
                     (req.noncache || req.writethru)) begin
            cause = CAUSE_ALIGN;
        end else if ((req.cls == CLS_LOAD_RESERVE ||
                      req.cls == CLS_STORE_COND) &&
                     word_misaligned(req.operand_ea)) begin
            cause = CAUSE_ALIGN;
        end else if (req.cls == CLS_CACHE_READ && !user_mode &&
                     word_misaligned(req.operand_ea)) begin
            cause = CAUSE_ALIGN;
        end
    end

endmodule // sexu_cause_decode

// ==== verilog/sexu_core.sv ====
// Synchronous exception unit: alignment, program, call; float instructions raise program
//
// Functional notes
// - Alignment interrupt vectors to 0x0600
// - Cache-zero to uncached or write-through faults
// - Misaligned load-reserve or store-conditional faults
// - Privileged misaligned cache-read faults
// - Alignment interrupt cannot be masked
// - Alignment saves faulting instruction address
// - Every interrupt copies prior machine state
// - Alignment captures faulting operand address
// - Entry clears listed machine-state bits
// - Illegal and float instructions raise program
// - Privileged instruction in user mode traps
// - Satisfied trap raises program, saves itself
// - Program saves faulting instruction address
// - Program interrupt cannot be masked
// - Program syndrome bits follow the cause
// - Program keeps machine-check bit, clears rest
// - Unit, float, aux error bits never set
// - Float-unavailable interrupt never raised
// - System call vectors to 0x0C00, or to 0x0700 if privileged-only in user mode
// - System call saves next instruction address
module sexu_core
    import sexu_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Instruction at the exception point
    input wire logic PIPE_VALID,
    input sexu_req_s PIPE_REQ,
    // Machine-check event, software register writes
    input wire logic MCHK_EVENT,
    input sexu_spr_wr_s SPR_WR,
    // Exception answer to fetch and pipeline
    output logic EXC_TAKEN,
    output logic [VEC_W-1:0] EXC_VECTOR,
    output logic EXC_SUPPRESS,
    output logic INSTR_COMMIT,
    // Architectural state
    output logic [XLEN-1:0] MACHINE_STATE,
    output logic [XLEN-1:0] RETURN_ADDR,
    output logic [XLEN-1:0] SAVED_STATE,
    output logic [XLEN-1:0] SYNDROME,
    output logic [XLEN-1:0] FAULT_ADDR
);

    sexu_cause_e cause;
    logic take;
    logic [XLEN-1:0] next_machine_state;
    logic [XLEN-1:0] next_syndrome;

    // Cause of the presented instruction
    sexu_cause_decode u_decode (
        .req(PIPE_REQ),
        .user_mode(MACHINE_STATE[MS_USER_MODE]),
        .cause(cause)
    );

    // No enable gates any cause handled here
    assign take = PIPE_VALID && (cause != CAUSE_NONE);

    // Answer to fetch and pipeline, one cycle after the request
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            EXC_TAKEN <= 1'b0;
            EXC_VECTOR <= VEC_NONE;
            EXC_SUPPRESS <= 1'b0;
            INSTR_COMMIT <= 1'b0;
        end else begin
            EXC_TAKEN <= take;
            // Call and trap are not squashed (only call commits); other faults squash the instruction
            EXC_SUPPRESS <= take && cause != CAUSE_SYSCALL &&
                            cause != CAUSE_TRAP;
            INSTR_COMMIT <= PIPE_VALID &&
                            (cause == CAUSE_NONE || cause == CAUSE_SYSCALL);
            unique case (cause)
                CAUSE_NONE: EXC_VECTOR <= VEC_NONE;
                CAUSE_ALIGN: EXC_VECTOR <= VEC_ALIGN;
                CAUSE_ILLEGAL,
                CAUSE_PRIV,
                CAUSE_TRAP: EXC_VECTOR <= VEC_PROGRAM;
                CAUSE_SYSCALL: EXC_VECTOR <= VEC_SYSCALL;
                default: EXC_VECTOR <= VEC_NONE;
            endcase
            if (!PIPE_VALID) begin
                EXC_VECTOR <= VEC_NONE;
            end
        end
    end

    // Return address: faulting instruction, or the one after a call
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            RETURN_ADDR <= ADDR_RESET;
        end else if (take) begin
            if (cause == CAUSE_SYSCALL) begin
                RETURN_ADDR <= PIPE_REQ.instr_ea + INSTR_BYTES;
            end else begin
                RETURN_ADDR <= PIPE_REQ.instr_ea;
            end
        end else if (SPR_WR.en && SPR_WR.sel == SPR_RETURN_ADDR) begin
            RETURN_ADDR <= SPR_WR.data;
        end
    end

    // Saved copy of the machine state before entry
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            SAVED_STATE <= MS_RESET;
        end else if (take) begin
            SAVED_STATE <= MACHINE_STATE;
        end else if (SPR_WR.en && SPR_WR.sel == SPR_SAVED_STATE) begin
            SAVED_STATE <= SPR_WR.data;
        end
    end

    // Machine state: entry clears the listed bits, keeps the rest
    always_comb begin
        next_machine_state = MACHINE_STATE;
        if (take) begin
            next_machine_state = MACHINE_STATE & ~MS_CLEAR_MASK;
        end else if (SPR_WR.en && SPR_WR.sel == SPR_MACHINE_STATE) begin
            next_machine_state = SPR_WR.data;
        end
    end

    // Machine state register
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            MACHINE_STATE <= MS_RESET;
        end else begin
            MACHINE_STATE <= next_machine_state;
        end
    end

    // Syndrome: program cause bits, machine-check bit kept, rest cleared
    always_comb begin
        next_syndrome = SYNDROME;
        if (SPR_WR.en && SPR_WR.sel == SPR_SYNDROME) begin
            next_syndrome = SPR_WR.data;
        end
        if (take && (cause == CAUSE_ILLEGAL || cause == CAUSE_PRIV ||
                     cause == CAUSE_TRAP)) begin
            next_syndrome = ES_RESET;
            next_syndrome[ES_MCHK] = SYNDROME[ES_MCHK];
            next_syndrome[ES_ILLEGAL] = cause == CAUSE_ILLEGAL;
            next_syndrome[ES_PRIV] = cause == CAUSE_PRIV;
            next_syndrome[ES_TRAP] = cause == CAUSE_TRAP;
        end
        // No float or auxiliary unit: these bits stay clear
        next_syndrome[ES_UNIMPL] = 1'b0;
        next_syndrome[ES_FLOAT_ERR] = 1'b0;
        next_syndrome[ES_AUX_ERR] = 1'b0;
        // A machine check in the clearing cycle is not lost
        if (MCHK_EVENT) begin
            next_syndrome[ES_MCHK] = 1'b1;
        end
    end

    // Syndrome register
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            SYNDROME <= ES_RESET;
        end else begin
            SYNDROME <= next_syndrome;
        end
    end

    // Fault address: operand of a misaligned access or of a faulting cache-zero
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            FAULT_ADDR <= ADDR_RESET;
        end else if (take && cause == CAUSE_ALIGN) begin
            FAULT_ADDR <= PIPE_REQ.operand_ea;
        end else if (SPR_WR.en && SPR_WR.sel == SPR_FAULT_ADDR) begin
            FAULT_ADDR <= SPR_WR.data;
        end
    end

    // Checks on the answer and on captured state
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    // Misaligned reservation access from any mode
    sequence s_resv_misaligned;
        PIPE_VALID &&
        (PIPE_REQ.cls == CLS_LOAD_RESERVE ||
         PIPE_REQ.cls == CLS_STORE_COND) &&
        !(PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE]) &&
        word_misaligned(PIPE_REQ.operand_ea);
    endsequence

    // Cache-zero to uncached or write-through memory
    sequence s_zero_bad_attr;
        PIPE_VALID && PIPE_REQ.cls == CLS_CACHE_ZERO &&
        !(PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE]) &&
        (PIPE_REQ.noncache || PIPE_REQ.writethru);
    endsequence

    // Alignment entry with both addresses captured
    sequence s_align_entry;
        EXC_TAKEN && EXC_SUPPRESS && EXC_VECTOR == VEC_ALIGN &&
        FAULT_ADDR == $past(PIPE_REQ.operand_ea) &&
        RETURN_ADDR == $past(PIPE_REQ.instr_ea);
    endsequence

    a_resv_align: assert property (
        s_resv_misaligned |=> s_align_entry)
        else $error("misaligned reservation access not faulted");

    a_zero_align: assert property (
        s_zero_bad_attr |=> s_align_entry)
        else $error("cache-zero to bad memory not faulted");

    a_read_align: assert property (
        PIPE_VALID && PIPE_REQ.cls == CLS_CACHE_READ &&
        !MACHINE_STATE[MS_USER_MODE] &&
        word_misaligned(PIPE_REQ.operand_ea)
        |=> s_align_entry)
        else $error("privileged misaligned cache read not faulted");

    a_state_copy: assert property (
        EXC_TAKEN |-> SAVED_STATE == $past(MACHINE_STATE))
        else $error("saved state differs from prior machine state");

    a_state_clear: assert property (
        EXC_TAKEN |-> (MACHINE_STATE & MS_CLEAR_MASK) == MS_RESET &&
        (MACHINE_STATE & ~MS_CLEAR_MASK) ==
        ($past(MACHINE_STATE) & ~MS_CLEAR_MASK))
        else $error("machine state not cleared correctly on entry");

    a_illegal_op: assert property (
        PIPE_VALID && (PIPE_REQ.cls == CLS_FLOAT ||
                       PIPE_REQ.cls == CLS_ILLEGAL)
        |=> EXC_TAKEN && EXC_VECTOR == VEC_PROGRAM && EXC_SUPPRESS &&
        SYNDROME[ES_ILLEGAL] && !SYNDROME[ES_PRIV] && !SYNDROME[ES_TRAP])
        else $error("illegal instruction not reported");

    a_priv_user: assert property (
        PIPE_VALID && PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE] &&
        PIPE_REQ.cls != CLS_FLOAT && PIPE_REQ.cls != CLS_ILLEGAL
        |=> EXC_TAKEN && EXC_VECTOR == VEC_PROGRAM &&
        SYNDROME[ES_PRIV] && !SYNDROME[ES_ILLEGAL])
        else $error("privileged instruction in user mode not trapped");

    a_trap_return: assert property (
        PIPE_VALID && PIPE_REQ.cls == CLS_TRAP && PIPE_REQ.trap_hit &&
        !(PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE])
        |=> EXC_TAKEN && EXC_VECTOR == VEC_PROGRAM && SYNDROME[ES_TRAP] &&
        RETURN_ADDR == $past(PIPE_REQ.instr_ea))
        else $error("trap did not save its own address");

    a_mchk_kept: assert property (
        EXC_TAKEN && EXC_VECTOR == VEC_PROGRAM && !$past(MCHK_EVENT)
        |-> SYNDROME[ES_MCHK] == $past(SYNDROME[ES_MCHK]) &&
        SYNDROME[XLEN-1:ES_TRAP+1] == '0)
        else $error("program entry disturbed machine-check bit");

    a_absent_units: assert property (
        !SYNDROME[ES_UNIMPL] && !SYNDROME[ES_FLOAT_ERR] &&
        !SYNDROME[ES_AUX_ERR])
        else $error("absent-unit syndrome bit set");

    a_no_fp_vector: assert property (
        EXC_VECTOR != VEC_FP_UNAVAIL)
        else $error("float-unavailable vector raised");

    a_syscall_next: assert property (
        PIPE_VALID && PIPE_REQ.cls == CLS_SYSCALL &&
        !(PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE])
        |=> EXC_TAKEN && EXC_VECTOR == VEC_SYSCALL && !EXC_SUPPRESS &&
        INSTR_COMMIT && RETURN_ADDR == $past(PIPE_REQ.instr_ea) + INSTR_BYTES)
        else $error("system call entry wrong");

    a_quiet_idle: assert property (
        !PIPE_VALID |=> !EXC_TAKEN && !EXC_SUPPRESS && !INSTR_COMMIT)
        else $error("answer without a request");

    // Clean completion of an instruction with no fault
    sequence s_clean_commit;
        INSTR_COMMIT && !EXC_TAKEN && !EXC_SUPPRESS &&
        EXC_VECTOR == VEC_NONE;
    endsequence

    a_store_commit: assert property (
        PIPE_VALID && PIPE_REQ.cls == CLS_STORE_COND &&
        !(PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE]) &&
        !word_misaligned(PIPE_REQ.operand_ea)
        |=> s_clean_commit)
        else $error("aligned store-conditional did not commit");

    a_trap_effects: assert property (
        PIPE_VALID && PIPE_REQ.cls == CLS_TRAP && PIPE_REQ.trap_hit &&
        !(PIPE_REQ.priv_only && MACHINE_STATE[MS_USER_MODE])
        |=> !EXC_SUPPRESS && !INSTR_COMMIT)
        else $error("trap effects handled wrongly");

    a_fault_keep: assert property (
        EXC_TAKEN && EXC_VECTOR != VEC_ALIGN && !$past(SPR_WR.en)
        |-> $stable(FAULT_ADDR))
        else $error("fault address changed without alignment");

    a_mchk_set: assert property (
        MCHK_EVENT |=> SYNDROME[ES_MCHK])
        else $error("machine-check event lost");

endmodule // sexu_core

// ==== verilog/sexu_pkg.sv ====
// Shared constants, encodings and carriers of the synchronous exception unit
package sexu_pkg;

    // Widths
    localparam int XLEN = 32;
    localparam int VEC_W = 16;

    // Vector offsets
    localparam logic [VEC_W-1:0] VEC_NONE = 16'h0000;
    localparam logic [VEC_W-1:0] VEC_ALIGN = 16'h0600;
    localparam logic [VEC_W-1:0] VEC_PROGRAM = 16'h0700;
    localparam logic [VEC_W-1:0] VEC_FP_UNAVAIL = 16'h0800;
    localparam logic [VEC_W-1:0] VEC_SYSCALL = 16'h0c00;

    // Instruction size, word alignment bits
    localparam logic [XLEN-1:0] INSTR_BYTES = 32'h0000_0004;
    localparam logic [1:0] WORD_LSB_MASK = 2'h3;

    // Machine-state field positions
    localparam int MS_AUX_UNIT_EN = 0;
    localparam int MS_AUX_EXC_EN = 1;
    localparam int MS_WAIT_EN = 2;
    localparam int MS_CRIT_EN = 3;
    localparam int MS_EXT_EN = 4;
    localparam int MS_USER_MODE = 5;
    localparam int MS_FLOAT_EN = 6;
    localparam int MS_MCHK_EN = 7;
    localparam int MS_FEXC_LOW = 8;
    localparam int MS_DBG_WAIT_EN = 9;
    localparam int MS_DBG_INT_EN = 10;
    localparam int MS_FEXC_HIGH = 11;
    localparam int MS_ITRANS_EN = 12;
    localparam int MS_DTRANS_EN = 13;

    // Machine-state bits cleared on entry to any handler here
    localparam logic [XLEN-1:0] MS_CLEAR_MASK = XLEN'(
        (1 << MS_AUX_UNIT_EN) | (1 << MS_AUX_EXC_EN) | (1 << MS_WAIT_EN) |
        (1 << MS_EXT_EN) | (1 << MS_USER_MODE) | (1 << MS_FLOAT_EN) |
        (1 << MS_FEXC_LOW) | (1 << MS_DBG_WAIT_EN) | (1 << MS_FEXC_HIGH) |
        (1 << MS_ITRANS_EN) | (1 << MS_DTRANS_EN));

    // Syndrome field positions
    localparam int ES_MCHK = 0;
    localparam int ES_ILLEGAL = 1;
    localparam int ES_PRIV = 2;
    localparam int ES_TRAP = 3;
    localparam int ES_UNIMPL = 4;
    localparam int ES_FLOAT_ERR = 5;
    localparam int ES_AUX_ERR = 6;

    // Reset values
    localparam logic [XLEN-1:0] MS_RESET = 32'h0000_0000;
    localparam logic [XLEN-1:0] ES_RESET = 32'h0000_0000;
    localparam logic [XLEN-1:0] ADDR_RESET = 32'h0000_0000;

    // Instruction classes seen by the unit
    typedef enum logic [3:0] {
        CLS_OTHER, CLS_CACHE_ZERO, CLS_LOAD_RESERVE, CLS_STORE_COND,
        CLS_CACHE_READ, CLS_FLOAT, CLS_ILLEGAL, CLS_TRAP, CLS_SYSCALL
    } sexu_class_e;

    // Exception causes
    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_ALIGN, CAUSE_ILLEGAL, CAUSE_PRIV, CAUSE_TRAP,
        CAUSE_SYSCALL
    } sexu_cause_e;

    // Special registers reachable by software moves
    typedef enum logic [2:0] {
        SPR_MACHINE_STATE, SPR_RETURN_ADDR, SPR_SAVED_STATE, SPR_SYNDROME,
        SPR_FAULT_ADDR
    } sexu_spr_e;

    // Instruction reaching the exception point
    typedef struct packed {
        sexu_class_e cls;
        logic priv_only;
        logic noncache;
        logic writethru;
        logic trap_hit;
        logic [XLEN-1:0] instr_ea;
        logic [XLEN-1:0] operand_ea;
    } sexu_req_s;

    // Software register write
    typedef struct packed {
        logic en;
        sexu_spr_e sel;
        logic [XLEN-1:0] data;
    } sexu_spr_wr_s;

    // Operand not on a word boundary
    function automatic logic word_misaligned(input logic [XLEN-1:0] ea);
        return |(ea[1:0] & WORD_LSB_MASK);
    endfunction

endpackage
